//--- srb_pkg.sv
// Purpose: Shared constants and types of the switch reset and boot-mode controller
// Assumes: One 200 MHz clock, AHB-Lite register access with 32-bit data
// Notes: Strap codes, register offsets and status field positions live here only
package srb_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 5;

    // Strap and sequencer state widths
    localparam int SW_CFG_W = 4;
    localparam int CLK_MODE_W = 2;
    localparam int STATE_W = 3;

    // Reference clock select codes
    localparam logic REF_SEL_100 = 1'h0;
    localparam logic REF_SEL_125 = 1'h1;

    // Switch configuration strap codes
    localparam logic [SW_CFG_W-1:0] SW_SINGLE = 4'h0;
    localparam logic [SW_CFG_W-1:0] SW_SINGLE_EEPROM = 4'h1;
    localparam logic [SW_CFG_W-1:0] SW_SINGLE_JUMP0 = 4'h2;
    localparam logic [SW_CFG_W-1:0] SW_SINGLE_JUMP1 = 4'h3;
    localparam logic [SW_CFG_W-1:0] SW_RSVD_FIRST = 4'h4;
    localparam logic [SW_CFG_W-1:0] SW_RSVD_LAST = 4'h7;
    localparam logic [SW_CFG_W-1:0] SW_LOWLAT = 4'h8;
    localparam logic [SW_CFG_W-1:0] SW_LOWLAT_EEPROM = 4'h9;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_UNATT = 4'hA;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_UNATT_I2C = 4'hB;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_UNATT_EEPROM = 4'hC;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_UNATT_BOTH = 4'hD;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_DIS = 4'hE;
    localparam logic [SW_CFG_W-1:0] SW_MULTI_DIS_EEPROM = 4'hF;

    // Decoded mode flag positions
    localparam int MF_W = 9;
    localparam int MF_MULTI = 0;
    localparam int MF_EEPROM = 1;
    localparam int MF_JUMP0 = 2;
    localparam int MF_JUMP1 = 3;
    localparam int MF_LOWLAT = 4;
    localparam int MF_I2CRST = 5;
    localparam int MF_UNATT = 6;
    localparam int MF_DISPORT = 7;
    localparam int MF_RESERVED = 8;

    // Register map
    localparam int AHB_AW = 32;
    localparam int AHB_DW = 32;
    localparam logic [AHB_AW-1:0] SWITCH_CONTROL_REG_OFF = 32'h0000_0000;
    localparam logic [AHB_AW-1:0] SWITCH_STATUS_REG_OFF = 32'h0000_0004;
    localparam int CTL_HOLD_BIT = 0;
    localparam int STS_STATE_LSB = 0;
    localparam int STS_REF125_BIT = 3;
    localparam int STS_PORT_CLOCKING_SELECT_LSB = 4;
    localparam int STS_SWCFG_LSB = 8;
    localparam int STS_FLAGS_LSB = 16;

    // AHB codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Sequencer states, one-hot
    typedef enum logic [STATE_W-1:0] {
        ST_RESET = 3'h1,
        ST_HOLD = 3'h2,
        ST_RUN = 3'h4
    } srb_state_type;

endpackage : srb_pkg

//--- srb_sync.sv
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous board pins
// Notes: A bit changes only once the second and third stages agree
`timescale 1ns/1ps
module srb_sync #(
    parameter int WIDTH = 9,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pins and filtered result
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("srb_sync: WIDTH must be at least one");
    end

    // First stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            stable_q <= RESET_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign stable = stable_q;

endmodule : srb_sync

//--- srb_reset_ctrl.sv
// Purpose: Fundamental reset, reset-hold sequencing and boot strap decode of a packet switch
// Assumes: Board pins are asynchronous; register path (SMBus bridge) arrives as AHB-Lite
// Notes: Zero-wait-state slave, always OKAY; straps latched at reset release
// Functional notes
// [RULE1] Fundamental reset pin low puts all internal logic into reset state; the code keeps the AHB slave answering reads and the hold latch sampling.
// [RULE2] Reference select 0 means 100 MHz reference, 1 means 125 MHz.
// [RULE3] Hold pin seen during reset keeps device in quasi-reset, SMBus alive.
// [RULE4] Register reads and writes work while in quasi-reset.
// [RULE5] Quasi-reset ends only when the master clears the hold control bit.
// [RULE6] Board keeps switch configuration straps steady after reset release.
// [RULE7] Codes 0-3: single partition, plain, EEPROM, jump-0, jump-1.
// [RULE8] Codes 4-7 reserved; device flags them, enables no mode.
// [RULE9] Code 8 reduced latency, code 9 adds EEPROM initialization.
// [RULE10] Codes A-D multi-partition unattached: plain, I2C reset, EEPROM, both.
// [RULE11] Code E multi-partition disabled ports, F adds EEPROM initialization.
// [RULE12] Two clocking-mode straps select port clocking scheme.
// [RULE13] Straps captured at reset release and held until next fundamental reset.
`timescale 1ns/1ps
module srb_reset_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Board reset and strap pins
    input wire logic fundamental_reset_n,
    input wire logic reset_hold,
    input wire logic [srb_pkg::SW_CFG_W-1:0] switch_config_select,
    input wire logic [srb_pkg::CLK_MODE_W-1:0] port_clocking_select,
    input wire logic ref_clock_freq_select,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [srb_pkg::AHB_AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [srb_pkg::AHB_DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [srb_pkg::AHB_DW-1:0] hrdata,
    // Reset and configuration outputs
    output logic core_reset,
    output logic smbus_active,
    output logic ref_clock_125mhz,
    output logic [srb_pkg::CLK_MODE_W-1:0] port_clock_mode,
    output logic [srb_pkg::SW_CFG_W-1:0] switch_config,
    output logic [srb_pkg::MF_W-1:0] switch_mode_flags
);
    import srb_pkg::*;

    // Synchronised pins
    logic prst_n_s;
    logic hold_s;
    logic [CLK_MODE_W-1:0] clkm_s;
    logic [SW_CFG_W-1:0] swcfg_s;
    logic fsel_s;
    logic [SW_CFG_W+CLK_MODE_W+2:0] sync_out;

    // Sequencer and strap state
    srb_state_type state_q, state_d;
    logic hold_seen_q, hold_seen_d;
    logic hold_bit_q, hold_bit_d;
    logic [SW_CFG_W-1:0] cfg_q, cfg_d;
    logic [CLK_MODE_W-1:0] clkm_q, clkm_d;
    logic fsel_q, fsel_d;
    logic capture;

    // Output flops
    logic core_reset_q, core_reset_d;
    logic smbus_active_q, smbus_active_d;
    logic ref125_q, ref125_d;
    logic [MF_W-1:0] flags_q, flags_d;
    logic hreadyout_q, hreadyout_d;
    logic hresp_q, hresp_d;

    // Bus state
    logic wr_pend_q, wr_pend_d;
    logic [AHB_AW-1:0] addr_q, addr_d;
    logic [AHB_DW-1:0] rdata_q, rdata_d;
    logic ahb_take;
    logic ctl_write;
    logic size_unused;

    // Pins are asynchronous; default value holds the device in reset
    srb_sync #(
        .WIDTH(SW_CFG_W + CLK_MODE_W + 3),
        .RESET_VAL('0)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .pin({fundamental_reset_n, reset_hold, port_clocking_select, switch_config_select, ref_clock_freq_select}),
        .stable(sync_out)
    );

    assign {prst_n_s, hold_s, clkm_s, swcfg_s, fsel_s} = sync_out;

    // Only whole-word transfers are expected
    assign size_unused = |hsize;

    assign ahb_take = hsel && (htrans == HTRANS_NONSEQ) && hready;
    // Writes landing during full reset are dropped
    assign ctl_write = wr_pend_q && (addr_q == SWITCH_CONTROL_REG_OFF) && (state_q != ST_RESET); // [RULE4]
    assign capture = (state_q == ST_RESET) && prst_n_s;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        hold_seen_d = hold_seen_q;
        hold_bit_d = hold_bit_q;
        cfg_d = cfg_q;
        clkm_d = clkm_q;
        fsel_d = fsel_q;
        if (!prst_n_s) begin
            state_d = ST_RESET; // [RULE1]
            hold_bit_d = 1'b0;
            cfg_d = SW_SINGLE;
            clkm_d = '0;
            fsel_d = REF_SEL_100;
            hold_seen_d = hold_seen_q | hold_s; // [RULE3]
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    // Straps frozen here; later pin motion is ignored
                    cfg_d = swcfg_s; // [RULE13] [RULE6]
                    clkm_d = clkm_s; // [RULE12]
                    fsel_d = fsel_s; // [RULE2]
                    hold_seen_d = 1'b0;
                    if (hold_seen_q || hold_s) begin
                        state_d = ST_HOLD; // [RULE3]
                        hold_bit_d = 1'b1;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
                ST_HOLD: begin
                    if (ctl_write && !hwdata[CTL_HOLD_BIT]) begin
                        state_d = ST_RUN; // [RULE5]
                        hold_bit_d = 1'b0;
                    end
                end
                ST_RUN: begin
                    hold_bit_d = 1'b0;
                end
                default: begin
                    state_d = ST_RESET;
                    hold_bit_d = 1'b0;
                end
            endcase
        end
    end

    // Strap decode
    always_comb begin
        flags_d = '0;
        unique case (cfg_q)
            SW_SINGLE: flags_d = '0; // [RULE7]
            SW_SINGLE_EEPROM: flags_d[MF_EEPROM] = 1'b1; // [RULE7]
            SW_SINGLE_JUMP0: begin
                flags_d[MF_EEPROM] = 1'b1; // [RULE7]
                flags_d[MF_JUMP0] = 1'b1;
            end
            SW_SINGLE_JUMP1: begin
                flags_d[MF_EEPROM] = 1'b1; // [RULE7]
                flags_d[MF_JUMP1] = 1'b1;
            end
            SW_LOWLAT: flags_d[MF_LOWLAT] = 1'b1; // [RULE9]
            SW_LOWLAT_EEPROM: begin
                flags_d[MF_LOWLAT] = 1'b1; // [RULE9]
                flags_d[MF_EEPROM] = 1'b1;
            end
            SW_MULTI_UNATT, SW_MULTI_UNATT_I2C, SW_MULTI_UNATT_EEPROM, SW_MULTI_UNATT_BOTH: begin
                flags_d[MF_MULTI] = 1'b1; // [RULE10]
                flags_d[MF_UNATT] = 1'b1;
                flags_d[MF_I2CRST] = (cfg_q == SW_MULTI_UNATT_I2C) || (cfg_q == SW_MULTI_UNATT_BOTH);
                flags_d[MF_EEPROM] = (cfg_q == SW_MULTI_UNATT_EEPROM) || (cfg_q == SW_MULTI_UNATT_BOTH);
            end
            SW_MULTI_DIS, SW_MULTI_DIS_EEPROM: begin
                flags_d[MF_MULTI] = 1'b1; // [RULE11]
                flags_d[MF_DISPORT] = 1'b1;
                flags_d[MF_EEPROM] = (cfg_q == SW_MULTI_DIS_EEPROM);
            end
            // Reserved codes enable nothing, only raise the marker
            default: flags_d[MF_RESERVED] = 1'b1; // [RULE8]
        endcase
    end

    // Output next values
    always_comb begin
        core_reset_d = (state_d != ST_RUN); // [RULE1] [RULE3]
        smbus_active_d = (state_d != ST_RESET); // [RULE3]
        ref125_d = (fsel_q == REF_SEL_125); // [RULE2]
        // Zero wait states and never an error, but still registered outputs
        hreadyout_d = 1'b1;
        hresp_d = HRESP_OKAY;
    end

    // Bus next values; reads see this cycle's pending write
    always_comb begin
        wr_pend_d = ahb_take && hwrite;
        addr_d = ahb_take ? haddr : addr_q;
        rdata_d = '0;
        if (ahb_take && !hwrite) begin
            if (haddr == SWITCH_CONTROL_REG_OFF) begin
                rdata_d[CTL_HOLD_BIT] = hold_bit_d; // [RULE4]
            end else if (haddr == SWITCH_STATUS_REG_OFF) begin
                rdata_d[STS_STATE_LSB +: STATE_W] = state_d;
                rdata_d[STS_REF125_BIT] = ref125_d;
                rdata_d[STS_PORT_CLOCKING_SELECT_LSB +: CLK_MODE_W] = clkm_q;
                rdata_d[STS_SWCFG_LSB +: SW_CFG_W] = cfg_q;
                rdata_d[STS_FLAGS_LSB +: MF_W] = flags_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_RESET;
            hold_seen_q <= 1'b0;
            hold_bit_q <= 1'b0;
            cfg_q <= SW_SINGLE;
            clkm_q <= '0;
            fsel_q <= REF_SEL_100;
            core_reset_q <= 1'b1;
            smbus_active_q <= 1'b0;
            ref125_q <= 1'b0;
            flags_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
            wr_pend_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            hold_seen_q <= hold_seen_d;
            hold_bit_q <= hold_bit_d;
            cfg_q <= cfg_d;
            clkm_q <= clkm_d;
            fsel_q <= fsel_d;
            core_reset_q <= core_reset_d;
            smbus_active_q <= smbus_active_d;
            ref125_q <= ref125_d;
            flags_q <= flags_d;
            hreadyout_q <= hreadyout_d;
            hresp_q <= hresp_d;
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = rdata_q;
    assign core_reset = core_reset_q;
    assign smbus_active = smbus_active_q;
    assign ref_clock_125mhz = ref125_q;
    assign port_clock_mode = clkm_q;
    assign switch_config = cfg_q;
    assign switch_mode_flags = flags_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_fund_reset_core: assert property (!prst_n_s |=> core_reset_q && state_q == ST_RESET) // [RULE1]
        else $error("core reset not applied under fundamental reset");
    chk_ref_select: assert property (capture |=> ##1 ref125_q == $past(fsel_s, 2)) // [RULE2]
        else $error("reference select not reflected");
    chk_hold_entry: assert property (capture && (hold_seen_q || hold_s) |=> state_q == ST_HOLD ##1 // [RULE3]
        (core_reset_q && smbus_active_q))
        else $error("quasi-reset not entered");
    chk_hold_release: assert property (state_q == ST_HOLD && prst_n_s && ctl_write && !hwdata[CTL_HOLD_BIT] // [RULE5]
        |=> state_q == ST_RUN ##1 !core_reset_q)
        else $error("hold clear did not release device");
    chk_hold_stays: assert property (state_q == ST_HOLD && prst_n_s && !ctl_write |=> state_q == ST_HOLD) // [RULE5]
        else $error("left quasi-reset without clear");
    chk_hold_readback: assert property (ahb_take && !hwrite && haddr == SWITCH_CONTROL_REG_OFF // [RULE4]
        && state_q == ST_HOLD && !ctl_write && prst_n_s |=> hrdata[CTL_HOLD_BIT])
        else $error("hold bit not readable in quasi-reset");
    chk_single_modes: assert property (capture && swcfg_s == SW_SINGLE_JUMP1 |=> ##1 // [RULE7]
        flags_q[MF_EEPROM] && flags_q[MF_JUMP1] && !flags_q[MF_MULTI])
        else $error("single partition jump decode wrong");
    chk_reserved_code: assert property (capture && swcfg_s >= SW_RSVD_FIRST && swcfg_s <= SW_RSVD_LAST // [RULE8]
        |=> ##1 flags_q == (MF_W'(1) << MF_RESERVED))
        else $error("reserved code enabled a mode");
    chk_lowlat_mode: assert property (capture && swcfg_s == SW_LOWLAT_EEPROM |=> ##1 // [RULE9]
        flags_q[MF_LOWLAT] && flags_q[MF_EEPROM] && !flags_q[MF_MULTI])
        else $error("reduced latency decode wrong");
    chk_multi_unatt: assert property (capture && swcfg_s == SW_MULTI_UNATT_I2C |=> ##1 // [RULE10]
        flags_q[MF_MULTI] && flags_q[MF_UNATT] && flags_q[MF_I2CRST] && !flags_q[MF_EEPROM])
        else $error("unattached multi-partition decode wrong");
    chk_multi_dis: assert property (capture && swcfg_s == SW_MULTI_DIS |=> ##1 // [RULE11]
        flags_q[MF_MULTI] && flags_q[MF_DISPORT] && !flags_q[MF_EEPROM])
        else $error("disabled-port decode wrong");
    chk_clock_mode: assert property (capture |=> port_clock_mode == $past(clkm_s)) // [RULE12]
        else $error("clocking mode not captured");
    chk_strap_freeze: assert property (state_q != ST_RESET && prst_n_s |=> $stable(cfg_q)) // [RULE13]
        else $error("strap changed after release");

    cov_hold_entered: cover property (capture && hold_s ##1 state_q == ST_HOLD);
    cov_hold_released: cover property (state_q == ST_HOLD ##1 state_q == ST_RUN);
    cov_direct_run: cover property (capture && !hold_s && !hold_seen_q ##1 state_q == ST_RUN);
    cov_reserved: cover property (flags_q[MF_RESERVED] && state_q == ST_RUN);
    cov_hold_kept: cover property (ctl_write && state_q == ST_HOLD && hwdata[CTL_HOLD_BIT]);

endmodule : srb_reset_ctrl

//--- srb_board_model.sv
// Purpose: Board reset and strap driver facing the reset controller
// Assumes: Driven from the bench through its tasks, changes just after a rising edge
// Notes: Straps only move while the reset pin is low, except in disturb
`timescale 1ns/1ps
module srb_board_model (
    // Clock
    input wire logic clk,
    // Board pins
    output logic fundamental_reset_n,
    output logic reset_hold,
    output logic [srb_pkg::SW_CFG_W-1:0] switch_config_select,
    output logic [srb_pkg::CLK_MODE_W-1:0] port_clocking_select,
    output logic ref_clock_freq_select
);
    import srb_pkg::*;

    initial begin
        fundamental_reset_n = 1'b0;
        reset_hold = 1'b0;
        switch_config_select = 4'h0;
        port_clocking_select = 2'h0;
        ref_clock_freq_select = 1'b0;
    end

    task apply_reset(input logic [SW_CFG_W-1:0] c, input logic [CLK_MODE_W-1:0] k, input logic f, input logic h);
        @(posedge clk);
        fundamental_reset_n <= 1'b0;
        reset_hold <= h;
        // Reserved codes only when the bench asks for them
        switch_config_select <= c;
        port_clocking_select <= k;
        ref_clock_freq_select <= f;
        repeat (10) @(posedge clk);
        fundamental_reset_n <= 1'b1;
        // Hold outlives the pin filter so the release cycle still sees it
        repeat (10) @(posedge clk);
        reset_hold <= 1'b0;
    endtask : apply_reset

    // Deliberately breaks the steady-strap promise
    task disturb;
        @(posedge clk);
        switch_config_select <= ~switch_config_select;
        port_clocking_select <= ~port_clocking_select;
        ref_clock_freq_select <= ~ref_clock_freq_select;
    endtask : disturb

    task hold_reset;
        @(posedge clk);
        fundamental_reset_n <= 1'b0;
    endtask : hold_reset

endmodule : srb_board_model

//--- srb_reset_ctrl_test.sv
// Purpose: Self-checking bench of the reset and boot-mode controller
// Assumes: Zero-wait AHB-Lite slave, board pins from srb_board_model
// Notes: Driver queues expectations, a monitor pops them as results appear
`timescale 1ns/1ps
module srb_reset_ctrl_test;
    import srb_pkg::*;
    typedef struct {string name; logic [31:0] val; logic [31:0] mask;} srb_exp_type;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp, core_reset, smbus_active, ref_clock_125mhz;
    logic [31:0] hrdata;
    logic [CLK_MODE_W-1:0] port_clock_mode, port_clocking_select;
    logic [SW_CFG_W-1:0] switch_config, switch_config_select;
    logic [MF_W-1:0] switch_mode_flags;
    logic fundamental_reset_n, reset_hold, ref_clock_freq_select;
    srb_exp_type q[$];
    int n_errors = 0;
    int n_checks = 0;
    int cfg_cnt = 0;
    logic rd_dph = 1'b0;
    logic smb_prev = 1'b0;

    assign hready = hreadyout;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

    srb_board_model board (.clk(clk), .fundamental_reset_n(fundamental_reset_n), .reset_hold(reset_hold),
        .switch_config_select(switch_config_select), .port_clocking_select(port_clocking_select),
        .ref_clock_freq_select(ref_clock_freq_select));

    srb_reset_ctrl uut (.clk(clk), .reset(reset), .fundamental_reset_n(fundamental_reset_n),
        .reset_hold(reset_hold), .switch_config_select(switch_config_select),
        .port_clocking_select(port_clocking_select), .ref_clock_freq_select(ref_clock_freq_select),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_reset(core_reset),
        .smbus_active(smbus_active), .ref_clock_125mhz(ref_clock_125mhz), .port_clock_mode(port_clock_mode),
        .switch_config(switch_config), .switch_mode_flags(switch_mode_flags));

    function automatic logic [MF_W-1:0] exp_flags(input logic [3:0] c);
        logic [MF_W-1:0] f;
        f = '0;
        f[MF_EEPROM] = c inside {4'h1, 4'h2, 4'h3, 4'h9, 4'hC, 4'hD, 4'hF};
        f[MF_JUMP0] = c == 4'h2;
        f[MF_JUMP1] = c == 4'h3;
        f[MF_RESERVED] = c inside {[4'h4:4'h7]};
        f[MF_LOWLAT] = c inside {4'h8, 4'h9};
        f[MF_MULTI] = c >= 4'hA;
        f[MF_UNATT] = c inside {[4'hA:4'hD]};
        f[MF_I2CRST] = c inside {4'hB, 4'hD};
        f[MF_DISPORT] = c >= 4'hE;
        return f;
    endfunction : exp_flags

    function automatic logic [31:0] status(input logic [3:0] c, input logic [1:0] k, input logic f);
        return (32'(exp_flags(c)) << STS_FLAGS_LSB) | (32'(c) << STS_SWCFG_LSB)
            | (32'(k) << STS_PORT_CLOCKING_SELECT_LSB) | (32'(f) << STS_REF125_BIT);
    endfunction : status

    task summarize;
        // A note never matched by a result is a missed check
        if (q.size() != 0) begin
            n_errors++;
            $display("ERROR queue expected 0 entries seen %0d", q.size());
        end
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task pop_cmp(input logic [31:0] v);
        srb_exp_type e;
        n_checks++;
        if (q.size() == 0) begin
            n_errors++;
            $display("ERROR result expected none seen %h", v);
        end else begin
            e = q.pop_front();
            if ((v & e.mask) !== (e.val & e.mask)) begin
                n_errors++;
                $display("ERROR %s expected %h seen %h", e.name, e.val, v);
            end
        end
    endtask : pop_cmp

    // Single word transfer; the wait is bounded even though the slave never stalls
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
        if (n >= 50) begin
            n_errors++;
            $display("ERROR hready expected 1 seen %b", hready);
            summarize();
        end
    endtask : xfer

    task rd(input logic [31:0] a, input string nm, input logic [31:0] v, input logic [31:0] m);
        q.push_back('{nm, v, m});
        xfer(a, 1'b0, 32'h0);
    endtask : rd

    task wait_out(input logic c, input logic s);
        int n;
        n = 0;
        n_checks++;
        while ((core_reset !== c || smbus_active !== s) && n < 100) begin @(posedge clk); n++; end
        if (n >= 100) begin
            n_errors++;
            $display("ERROR core_reset,smbus_active expected %b%b seen %b%b", c, s, core_reset, smbus_active);
            summarize();
        end
    endtask : wait_out

    // Flag and reference outputs settle one edge after the state, so compare a few edges past release
    always @(posedge clk) begin
        if (rd_dph) pop_cmp(hrdata);
        if (rd_dph && hresp !== HRESP_OKAY) begin
            n_errors++;
            $display("ERROR hresp expected %b seen %b", HRESP_OKAY, hresp);
        end
        if (cfg_cnt == 1) pop_cmp({14'h0, core_reset, smbus_active, ref_clock_125mhz, port_clock_mode,
            switch_config, switch_mode_flags});
        rd_dph <= hsel && htrans == HTRANS_NONSEQ && hready && !hwrite;
        cfg_cnt <= cfg_cnt > 0 ? cfg_cnt - 1 : ((smbus_active === 1'b1 && !smb_prev) ? 3 : 0);
        smb_prev <= smbus_active === 1'b1;
    end

    initial begin
        logic [3:0] c;
        logic [1:0] k;
        logic f, h;
        logic [31:0] st;
        void'($urandom(21));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            k = 2'($urandom % 4);
            f = 1'($urandom % 2);
            h = (i % 3) != 2;
            st = status(c, k, f);
            q.push_back('{"straps", {14'h0, h, 1'b1, f, k, c, exp_flags(c)}, '1});
            board.apply_reset(c, k, f, h);
            wait_out(h, 1'b1);
            repeat (4) @(posedge clk);
            if (h) begin
                rd(SWITCH_STATUS_REG_OFF, "status", st | 32'(ST_HOLD), '1);
                rd(SWITCH_CONTROL_REG_OFF, "control", 32'h1, '1);
                xfer(SWITCH_CONTROL_REG_OFF, 1'b1, 32'h1);
                xfer(SWITCH_STATUS_REG_OFF, 1'b1, 32'hFFFF_FFFF);
                rd(32'h0000_0010, "unmapped", 32'h0, '1);
                rd(SWITCH_STATUS_REG_OFF, "status", st | 32'(ST_HOLD), '1);
                xfer(SWITCH_CONTROL_REG_OFF, 1'b1, 32'h0);
                rd(SWITCH_CONTROL_REG_OFF, "control", 32'h0, '1);
                wait_out(1'b0, 1'b1);
            end
            if (i == 5) begin
                board.disturb();
                repeat (8) @(posedge clk);
            end
            rd(SWITCH_STATUS_REG_OFF, "status", st | 32'(ST_RUN), '1);
        end
        board.hold_reset();
        wait_out(1'b1, 1'b0);
        repeat (2) @(posedge clk);
        rd(SWITCH_STATUS_REG_OFF, "status", 32'(ST_RESET), '1);
        repeat (3) @(posedge clk);
        summarize();
    end

endmodule : srb_reset_ctrl_test
